// *** sdec_pkg.sv ***
package sdec_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] MASK_INDEX = 16'h1880;
    localparam logic [15:0] STATUS_INDEX = 16'h1881;
    localparam logic [17:0] MASK_ADDR = {MASK_INDEX, 2'b00};
    localparam logic [17:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};

    // Status and mask field positions
    localparam int PEND_BIT = 0;
    localparam int A_VALID_BIT = 1;
    localparam int A_PORT_LSB = 2;
    localparam int A_REASON_LSB = 4;
    localparam int B_VALID_BIT = 8;
    localparam int B_PORT_LSB = 9;
    localparam int B_REASON_LSB = 11;
    localparam int MASK_BIT = 0;

    localparam logic MASK_RESET = 1'b1;

    // Drop reason codes
    localparam logic [3:0] RSN_UNTAGGED = 4'h0;
    localparam logic [3:0] RSN_UNK_NONMEMBER = 4'h1;
    localparam logic [3:0] RSN_KNOWN_SRC_BLOCKED = 4'h2;
    localparam logic [3:0] RSN_KNOWN_DST_BLOCKED = 4'h3;
    localparam logic [3:0] RSN_KNOWN_DST_NONMEMBER = 4'h4;
    localparam logic [3:0] RSN_KNOWN_SRC_NONMEMBER = 4'h5;
    localparam logic [3:0] RSN_UNICAST_MISS = 4'h6;
    localparam logic [3:0] RSN_MULTICAST_MISS = 4'h7;
    localparam logic [3:0] RSN_BCAST_THROTTLE = 4'h8;
    localparam logic [3:0] RSN_UNK_SRC_BLOCKED = 4'h9;
    localparam logic [3:0] RSN_SAME_PORT = 4'hA;
    localparam logic [3:0] RSN_FILTERED = 4'hB;
    localparam logic [3:0] RSN_VID_ALL_ONES = 4'hE;

    // Drop cause flags from the forwarding logic
    typedef struct packed {
        logic untagged_refused;
        logic unknown_nonmember;
        logic known_src_blocked;
        logic known_dst_blocked;
        logic known_dst_nonmember;
        logic known_src_nonmember;
        logic unicast_miss;
        logic multicast_miss;
        logic bcast_throttled;
        logic unknown_src_blocked;
        logic same_port;
        logic filtered;
        logic vid_all_ones;
    } sdec_cause_s;

    typedef struct packed {
        logic [3:0] reason;
        logic [1:0] port;
        logic valid;
    } sdec_slot_s;

    typedef struct packed {
        sdec_slot_s b;
        sdec_slot_s a;
        logic pending;
    } sdec_status_s;

endpackage

// *** sdec_capture.sv ***
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module sdec_capture (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Drop events from the forwarding logic
    input wire logic drop_valid_i,
    input wire logic [1:0] drop_port_i,
    input wire sdec_pkg::sdec_cause_s drop_cause_i,
    // Interrupt towards the system aggregator
    output logic irq_o
);

    sdec_pkg::sdec_status_s status;
    sdec_pkg::sdec_status_s snap;
    sdec_pkg::sdec_status_s next_status;
    sdec_pkg::sdec_slot_s new_slot;
    logic mask;
    logic late;
    logic [3:0] next_reason;
    logic setup;
    logic done;
    logic hit_mask;
    logic hit_status;

    assign setup = psel_i && !penable_i;
    assign done = psel_i && penable_i && pready_o;
    assign hit_mask = (paddr_i == sdec_pkg::MASK_ADDR);
    assign hit_status = (paddr_i == sdec_pkg::STATUS_ADDR);

    function automatic logic [31:0] pack_status(input sdec_pkg::sdec_status_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[sdec_pkg::PEND_BIT] = s.pending;
        w[sdec_pkg::A_VALID_BIT] = s.a.valid;
        w[sdec_pkg::A_PORT_LSB +: 2] = s.a.port;
        w[sdec_pkg::A_REASON_LSB +: 4] = s.a.reason;
        w[sdec_pkg::B_VALID_BIT] = s.b.valid;
        w[sdec_pkg::B_PORT_LSB +: 2] = s.b.port;
        w[sdec_pkg::B_REASON_LSB +: 4] = s.b.reason;
        return w;
    endfunction

    // Lowest code wins when several causes are flagged at once
    always_comb begin
        next_reason = sdec_pkg::RSN_UNTAGGED;
        if (drop_cause_i.untagged_refused) begin
            next_reason = sdec_pkg::RSN_UNTAGGED;
        end else if (drop_cause_i.unknown_nonmember) begin
            next_reason = sdec_pkg::RSN_UNK_NONMEMBER;
        end else if (drop_cause_i.known_src_blocked) begin
            next_reason = sdec_pkg::RSN_KNOWN_SRC_BLOCKED;
        end else if (drop_cause_i.known_dst_blocked) begin
            next_reason = sdec_pkg::RSN_KNOWN_DST_BLOCKED;
        end else if (drop_cause_i.known_dst_nonmember) begin
            next_reason = sdec_pkg::RSN_KNOWN_DST_NONMEMBER;
        end else if (drop_cause_i.known_src_nonmember) begin
            next_reason = sdec_pkg::RSN_KNOWN_SRC_NONMEMBER;
        end else if (drop_cause_i.unicast_miss) begin
            next_reason = sdec_pkg::RSN_UNICAST_MISS;
        end else if (drop_cause_i.multicast_miss) begin
            next_reason = sdec_pkg::RSN_MULTICAST_MISS;
        end else if (drop_cause_i.bcast_throttled) begin
            next_reason = sdec_pkg::RSN_BCAST_THROTTLE;
        end else if (drop_cause_i.unknown_src_blocked) begin
            next_reason = sdec_pkg::RSN_UNK_SRC_BLOCKED;
        end else if (drop_cause_i.same_port) begin
            next_reason = sdec_pkg::RSN_SAME_PORT;
        end else if (drop_cause_i.filtered) begin
            next_reason = sdec_pkg::RSN_FILTERED;
        end else if (drop_cause_i.vid_all_ones) begin
            next_reason = sdec_pkg::RSN_VID_ALL_ONES;
        end
        // No path yields 1100, 1101 or 1111
    end

    always_comb begin
        new_slot.valid = 1'b1;
        new_slot.port = drop_port_i;
        new_slot.reason = next_reason;
    end

    // Capture and read-clear. A read clears only what its snapshot showed, so
    // an event arriving between snapshot and completion is never lost.
    always_comb begin
        sdec_pkg::sdec_slot_s keep_a;
        sdec_pkg::sdec_slot_s keep_b;
        keep_a = status.a;
        keep_b = status.b;
        next_status = status;
        if (done && !pwrite_i && hit_status) begin
            keep_a = (status.a.valid && !snap.a.valid) ? status.a : '0;
            keep_b = (status.b.valid && !snap.b.valid) ? status.b : '0;
            next_status = '0;
            next_status.pending = late;
            if (keep_a.valid) begin
                next_status.a = keep_a;
                next_status.b = keep_b;
            end else begin
                next_status.a = keep_b;
            end
        end
        // Set wins over clear in the same cycle
        if (drop_valid_i) begin
            next_status.pending = 1'b1;
            if (!next_status.a.valid) begin
                next_status.a = new_slot;
            end else if (!next_status.b.valid) begin
                next_status.b = new_slot;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // Tracks drops that land after the read snapshot was taken
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snap <= '0;
            late <= 1'b0;
        end else if (setup) begin
            // A drop on the setup edge is already missing from the snapshot
            snap <= status;
            late <= drop_valid_i;
        end else if (drop_valid_i) begin
            late <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask <= sdec_pkg::MASK_RESET;
        end else if (done && pwrite_i && hit_mask) begin
            mask <= pwdata_i[sdec_pkg::MASK_BIT];
        end
    end

    // Answer is prepared in the setup cycle so every bus output is a flop
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (setup) begin
            pready_o <= 1'b1;
            pslverr_o <= !(hit_mask || hit_status);
            prdata_o <= 32'h0000_0000;
            if (!pwrite_i && hit_status) begin
                prdata_o <= pack_status(status);
            end else if (!pwrite_i && hit_mask) begin
                prdata_o[sdec_pkg::MASK_BIT] <= mask;
            end
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_status.pending && !mask;
        end
    end

endmodule

// *** sdec_capture_chk.sv ***
`timescale 1ns/1ps
module sdec_capture_chk (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Drops and interrupt
    input wire logic drop_valid_i,
    input wire logic irq_o
);
    logic mask_q;
    logic rd_st;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    assign rd_st = pready_o && penable_i && !pwrite_i && paddr_i == sdec_pkg::STATUS_ADDR;
    // Shadow of the mask, so interrupt checks need no internal probe
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_q <= sdec_pkg::MASK_RESET;
        end else if (psel_i && penable_i && pready_o && pwrite_i
                     && paddr_i == sdec_pkg::MASK_ADDR) begin
            mask_q <= pwdata_i[0];
        end
    end
    a_ready_follow: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_err_decode: assert property (psel_i && !penable_i |=> pslverr_o ==
        ($past(paddr_i) != sdec_pkg::MASK_ADDR && $past(paddr_i) != sdec_pkg::STATUS_ADDR))
        else $error("wrong error response");
    a_irq_masked: assert property (mask_q |=> !irq_o)
        else $error("interrupt while masked");
    a_irq_raise: assert property (drop_valid_i && !mask_q ##1 !mask_q |=> irq_o)
        else $error("no interrupt after drop");
    a_resv_zero: assert property (rd_st |-> prdata_o[31:15] == 17'h0)
        else $error("reserved status bits set");
    a_no_resv_code: assert property (rd_st && prdata_o[1] |->
        !(prdata_o[7:4] inside {4'hC, 4'hD, 4'hF}))
        else $error("reserved reason code");
    a_valid_pend: assert property (rd_st && (prdata_o[1] || prdata_o[8]) |->
        prdata_o[0] && prdata_o[1])
        else $error("slot valid without pending or slot A");
endmodule
bind sdec_capture sdec_capture_chk sdec_capture_chk_inst (.clock_i(clock_i),
    .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .drop_valid_i(drop_valid_i), .irq_o(irq_o));

// *** test_switch_drop_event_capture.sv ***
`timescale 1ns/1ps
module test_switch_drop_event_capture;
    logic clock_i = 0, resetn_i = 0, psel = 0, pen = 0, pwr = 0, dv = 0, rdy, err, irq, e;
    logic [17:0] pa = 0;
    logic [31:0] pwd = 0, rd, r;
    logic [1:0] dp = 0;
    sdec_pkg::sdec_cause_s dc = '0;
    int error_cnt = 0, compares = 0, st = 0, c, p, k;
    sdec_capture sdec_capture_inst (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(rd),
        .pready_o(rdy), .pslverr_o(err), .drop_valid_i(dv), .drop_port_i(dp),
        .drop_cause_i(dc), .irq_o(irq));
    initial forever #4 clock_i = ~clock_i;
    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, g, x);
        end
    endtask
    task results;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clock_i);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        r = rd;
        e = err;
        psel <= 0;
        pen <= 0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask
    // Model clears its copy once the read has returned it
    task rdst;
        apb(0, sdec_pkg::STATUS_ADDR, 32'h0);
        chk(r, st);
        chk(32'(e), 32'h0);
        st = 0;
    endtask
    // Model clears before the read starts, so a drop racing the read lands in an empty model
    task rdrace(input int d, input int pt, input logic [12:0] cs);
        int old;
        old = st;
        st = 0;
        fork
            apb(0, sdec_pkg::STATUS_ADDR, 32'h0);
            begin
                repeat (d) @(posedge clock_i);
                drop(pt, cs);
            end
        join
        chk(r, old);
    endtask
    task drop(input int pt, input logic [12:0] cs);
        @(posedge clock_i);
        dv <= 1;
        dp <= pt[1:0];
        dc <= cs;
        @(posedge clock_i);
        dv <= 0;
        c = 0;
        for (k = 0; k <= 12; k++) begin
            if (cs[k]) c = (k == 0) ? 14 : 12 - k;
        end
        if (!st[1]) st[7:1] = {c[3:0], pt[1:0], 1'b1};
        else if (!st[8]) st[14:8] = {c[3:0], pt[1:0], 1'b1};
        st[0] = 1;
    endtask
    initial begin
        c = $urandom(73540);
        repeat (10) @(posedge clock_i);
        resetn_i <= 1;
        rdst;
        apb(0, sdec_pkg::MASK_ADDR, 32'h0);
        chk(r, 32'h1);
        chk(32'(irq), 32'h0);
        $display("reset test done");
        // Two codes per read fill A then B; the third drop only keeps pending
        for (p = 0; p < 13; p += 2) begin
            drop($urandom % 3, 13'h1 << p);
            drop($urandom % 3, 13'h1 << (p + 1));
            drop($urandom % 3, 13'($urandom));
            rdst;
        end
        repeat (6) begin
            drop($urandom % 3, 13'($urandom));
            rdst;
        end
        $display("code test done");
        // Drops on the setup or completion edge of a read must survive it
        for (p = 0; p < 4; p++) begin
            if (p[0]) drop($urandom % 3, 13'h1 << ($urandom % 13));
            rdrace(p >> 1, $urandom % 3, 13'($urandom));
            rdst;
        end
        $display("race test done");
        apb(1, sdec_pkg::MASK_ADDR, 32'h0);
        drop(2, 13'h2);
        repeat (2) @(posedge clock_i);
        chk(32'(irq), 32'h1);
        apb(1, sdec_pkg::MASK_ADDR, 32'h1);
        repeat (2) @(posedge clock_i);
        chk(32'(irq), 32'h0);
        rdst;
        $display("mask test done");
        apb(1, 18'h0008, 32'hFFFF_FFFF);
        chk(32'(e), 32'h1);
        apb(0, 18'h0008, 32'h0);
        chk(r, 32'h0);
        chk(32'(e), 32'h1);
        drop(1, 13'h4);
        apb(1, sdec_pkg::STATUS_ADDR, 32'h0);
        chk(32'(e), 32'h0);
        rdst;
        $display("access test done");
        apb(1, sdec_pkg::MASK_ADDR, 32'h0);
        drop(0, 13'h40);
        @(posedge clock_i);
        resetn_i <= 0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1;
        st = 0;
        chk(32'(irq), 32'h0);
        rdst;
        apb(0, sdec_pkg::MASK_ADDR, 32'h0);
        chk(r, 32'h1);
        $display("second reset test done");
        results;
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        chk(32'h0, 32'h1);
        results;
    end
endmodule
